// >>> design/opb_pkg.sv
package opb_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MODE_SETTLE_US = 10;
  localparam int unsigned MODE_SETTLE_CYC =
    (MODE_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROGRAMMING_MODE_TIME_US = 20;
  localparam int unsigned PROGRAMMING_MODE_CYC =
    (PROGRAMMING_MODE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Widths and modes
  // ****************************************************************
  localparam int unsigned PADDR_W = 13;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned MODE_W = 3;
  localparam logic [2:0] MODE_DSTBY = 3'h0;
  localparam logic [2:0] MODE_PROGRAMMING_MODE = 3'h3;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [31:0] OFS_MODE = 32'h07F40000;
  localparam logic [31:0] OFS_STATUS = 32'h07F40004;
  localparam logic [31:0] OFS_ADDR = 32'h07F40008;
  localparam logic [31:0] OFS_WORD = 32'h07F4000C;
  localparam logic [31:0] OFS_IRQ_ST = 32'h07F40040;
  localparam logic [31:0] OFS_IRQ_MASK = 32'h07F40044;

  localparam int unsigned ST_IDLE_BIT = 0;
  localparam int unsigned ST_EMPTY_BIT = 1;
  localparam int unsigned ST_MRDY_BIT = 2;
  localparam logic RST_IDLE = 1'b1;
  localparam logic RST_EMPTY = 1'b1;
  localparam logic RST_MRDY = 1'b1;
  localparam logic [12:0] RST_ADDR = 13'h0000;
  localparam logic [31:0] RST_WORD = 32'h00000000;

  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_FREE_BIT = 1;
  localparam int unsigned IRQ_MODE_BIT = 2;

  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_LOAD,
    ENG_BURN
  } opb_eng_e;

endpackage

// >>> design/opb_mode_ctrl.sv
module opb_mode_ctrl #(
  parameter int unsigned SETTLE_CYC = opb_pkg::MODE_SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr,
  input wire logic [opb_pkg::MODE_W-1:0] wdata,
  output logic [opb_pkg::MODE_W-1:0] mode,
  output logic ready,
  output logic done
);
  import opb_pkg::*;

  localparam int CW = $clog2(SETTLE_CYC + 1);

  if (SETTLE_CYC < 1 || SETTLE_CYC > 4096) begin : g_chk
    $error("settle count out of range");
  end

  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic ready;
    logic [CW-1:0] cnt;
    logic done;
  } opb_mode_s;

  opb_mode_s r, n;

  always_comb
  begin
    n = r;
    n.done = 1'b0;
    if (!r.ready)
    begin
      if (r.cnt == '0)
      begin
        n.ready = 1'b1;
        n.done = 1'b1;
      end
      else
      begin
        n.cnt = r.cnt - 1'b1;
      end
    end
    else if (wr && wdata != r.mode)
    begin
      n.mode = wdata;
      n.ready = 1'b0;
      n.cnt = CW'(SETTLE_CYC - 1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '{mode: MODE_DSTBY, ready: RST_MRDY, cnt: '0, done: 1'b0};
    end
    else
    begin
      r <= n;
    end
  end

  assign mode = r.mode;
  assign ready = r.ready;
  assign done = r.done;
endmodule

// >>> design/opb_programming_mode_engine.sv
module opb_programming_mode_engine #(
  parameter int unsigned BURN_CYC = opb_pkg::PROGRAMMING_MODE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic [opb_pkg::PADDR_W-1:0] req_addr,
  input wire logic [opb_pkg::WORD_W-1:0] req_word,
  output logic idle,
  output logic freed,
  output logic done,
  output logic programming_mode_en,
  output logic [opb_pkg::PADDR_W-1:0] programming_mode_addr,
  output logic [opb_pkg::WORD_W-1:0] programming_mode_word
);
  import opb_pkg::*;

  localparam int CW = $clog2(BURN_CYC + 1);

  if (BURN_CYC < 1 || BURN_CYC > 4096) begin : g_chk
    $error("burn count out of range");
  end

  typedef struct packed {
    opb_eng_e st;
    logic [CW-1:0] cnt;
    logic idle;
    logic freed;
    logic done;
    logic en;
    logic [PADDR_W-1:0] addr;
    logic [WORD_W-1:0] word;
  } opb_eng_s;

  opb_eng_s r, n;

  always_comb
  begin
    n = r;
    n.freed = 1'b0;
    n.done = 1'b0;
    case (r.st)
      ENG_IDLE:
      begin
        if (req)
        begin
          n.st = ENG_LOAD;
          n.idle = 1'b0;
          n.addr = req_addr;
          n.word = req_word;
        end
      end
      ENG_LOAD:
      begin
        n.st = ENG_BURN;
        n.freed = 1'b1;
        n.en = 1'b1;
        n.cnt = CW'(BURN_CYC - 1);
      end
      ENG_BURN:
      begin
        if (r.cnt == '0)
        begin
          n.st = ENG_IDLE;
          n.en = 1'b0;
          n.idle = 1'b1;
          n.done = 1'b1;
        end
        else
        begin
          n.cnt = r.cnt - 1'b1;
        end
      end
      default:
      begin
        n.st = ENG_IDLE;
        n.idle = 1'b1;
        n.en = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '{st: ENG_IDLE, cnt: '0, idle: RST_IDLE, freed: 1'b0, done: 1'b0,
             en: 1'b0, addr: '0, word: '0};
    end
    else
    begin
      r <= n;
    end
  end

  assign idle = r.idle;
  assign freed = r.freed;
  assign done = r.done;
  assign programming_mode_en = r.en;
  assign programming_mode_addr = r.addr;
  assign programming_mode_word = r.word;
endmodule

// >>> design/opb_program_buffer.sv
// The APB interface to the registers was left to the implementer.
module opb_program_buffer #(
  parameter int unsigned SETTLE_CYC = opb_pkg::MODE_SETTLE_CYC,
  parameter int unsigned BURN_CYC = opb_pkg::PROGRAMMING_MODE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic irq,
  output logic [opb_pkg::MODE_W-1:0] otp_mode,
  output logic otp_mode_ready,
  output logic otp_programming_mode_en,
  output logic [opb_pkg::PADDR_W-1:0] otp_programming_mode_addr,
  output logic [opb_pkg::WORD_W-1:0] otp_programming_mode_word
);
  import opb_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [PADDR_W-1:0] addr;
    logic [WORD_W-1:0] word;
    logic empty;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
  } opb_top_s;

  opb_top_s r, n;

  logic setup;
  logic acc_wr;
  logic mode_wr;
  logic trigger;
  logic programming_mode_active;
  logic [MODE_W-1:0] mode;
  logic mode_ready;
  logic mode_done;
  logic eng_idle;
  logic eng_freed;
  logic eng_done;
  logic [IRQ_W-1:0] events;
  logic [31:0] status_word;

  // ****************************************************************
  // Bus phases
  // ****************************************************************
  // The slave answers in the first access cycle: pready is raised
  // from the setup cycle so that it still comes from a flip-flop.
  assign setup = psel && !penable;
  assign acc_wr = psel && penable && pwrite && r.pready;
  assign mode_wr = acc_wr && paddr == OFS_MODE;
  assign programming_mode_active = mode == MODE_PROGRAMMING_MODE && mode_ready;
  // An address write only launches when the buffer was free and the
  // programming mode has finished settling.
  assign trigger = acc_wr && paddr == OFS_ADDR && r.empty
                   && programming_mode_active;

  assign events[IRQ_DONE_BIT] = eng_done;
  assign events[IRQ_FREE_BIT] = eng_freed;
  assign events[IRQ_MODE_BIT] = mode_done;

  always_comb
  begin
    status_word = 32'h00000000;
    status_word[ST_MRDY_BIT] = mode_ready;
    status_word[ST_EMPTY_BIT] = r.empty;
    status_word[ST_IDLE_BIT] = eng_idle;
  end

  // ****************************************************************
  // Mode tracking
  // ****************************************************************
  opb_mode_ctrl #(
    .SETTLE_CYC(SETTLE_CYC)
  ) u_mode (
    .pclk(pclk),
    .presetn(presetn),
    .wr(mode_wr),
    .wdata(pwdata[MODE_W-1:0]),
    .mode(mode),
    .ready(mode_ready),
    .done(mode_done)
  );

  // ****************************************************************
  // Programming engine
  // ****************************************************************
  opb_programming_mode_engine #(
    .BURN_CYC(BURN_CYC)
  ) u_eng (
    .pclk(pclk),
    .presetn(presetn),
    .req(!r.empty),
    .req_addr(r.addr),
    .req_word(r.word),
    .idle(eng_idle),
    .freed(eng_freed),
    .done(eng_done),
    .programming_mode_en(otp_programming_mode_en),
    .programming_mode_addr(otp_programming_mode_addr),
    .programming_mode_word(otp_programming_mode_word)
  );

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_comb
  begin
    n = r;
    n.pready = setup;
    n.pslverr = 1'b0;
    n.prdata = 32'h00000000;
    if (setup)
    begin
      case (paddr)
        OFS_MODE:
        begin
          n.prdata[MODE_W-1:0] = mode;
        end
        OFS_STATUS:
        begin
          n.prdata = status_word;
        end
        OFS_ADDR:
        begin
          n.prdata[PADDR_W-1:0] = r.addr;
        end
        OFS_WORD:
        begin
          n.prdata = r.word;
        end
        OFS_IRQ_ST:
        begin
          n.prdata[IRQ_W-1:0] = r.irq_st;
        end
        OFS_IRQ_MASK:
        begin
          n.prdata[IRQ_W-1:0] = r.irq_mask;
        end
        default:
        begin
          n.pslverr = 1'b1;
        end
      endcase
      if (pwrite)
      begin
        n.prdata = 32'h00000000;
      end
    end

    if (acc_wr)
    begin
      case (paddr)
        OFS_ADDR:
        begin
          if (r.empty)
          begin
            n.addr = pwdata[PADDR_W-1:0];
          end
        end
        OFS_WORD:
        begin
          if (r.empty)
          begin
            n.word = pwdata;
          end
        end
        OFS_IRQ_MASK:
        begin
          n.irq_mask = pwdata[IRQ_W-1:0];
        end
        default:
        begin
          n.irq_mask = r.irq_mask;
        end
      endcase
    end

    if (trigger)
    begin
      n.empty = 1'b0;
    end
    else if (eng_freed)
    begin
      n.empty = 1'b1;
    end

    // Status bits clear on a one written, but a new event in the same
    // cycle wins so that no event is dropped.
    if (acc_wr && paddr == OFS_IRQ_ST)
    begin
      n.irq_st = r.irq_st & ~pwdata[IRQ_W-1:0];
    end
    n.irq_st = n.irq_st | events;
    n.irq = |(n.irq_st & n.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000,
             addr: RST_ADDR, word: RST_WORD, empty: RST_EMPTY,
             irq_st: '0, irq_mask: '0, irq: 1'b0};
    end
    else
    begin
      r <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign prdata = r.prdata;
  assign irq = r.irq;
  assign otp_mode = mode;
  assign otp_mode_ready = mode_ready;
endmodule

// >>> bench/opb_program_buffer_chk.sv
module opb_program_buffer_chk #(
  parameter int unsigned SETTLE_CYC = 4,
  parameter int unsigned BURN_CYC = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [opb_pkg::MODE_W-1:0] otp_mode,
  input wire logic otp_mode_ready,
  input wire logic otp_programming_mode_en,
  input wire logic [opb_pkg::PADDR_W-1:0] otp_programming_mode_addr,
  input wire logic [opb_pkg::WORD_W-1:0] otp_programming_mode_word
);
  timeunit 1ns;
  timeprecision 1ns;
  import opb_pkg::*;
  logic wr;
  logic [15:0] low_n;
  logic [15:0] burn_n;
  logic [31:0] word_q;
  assign wr = psel && penable && pready && pwrite;
  // Counters time the settle and burn phases, so no long repetition is unrolled.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_n <= '0;
      burn_n <= '0;
      word_q <= '0;
    end
    else
    begin
      low_n <= otp_mode_ready ? 16'h0000 : low_n + 16'h0001;
      burn_n <= otp_programming_mode_en ? burn_n + 16'h0001 : 16'h0000;
      if (wr && paddr == OFS_WORD)
        word_q <= pwdata;
    end
  end
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_trig;
    wr && paddr == OFS_ADDR && otp_mode == MODE_PROGRAMMING_MODE && otp_mode_ready && !otp_programming_mode_en
      && !$past(otp_programming_mode_en);
  endsequence
  sequence s_launch;
    ##2 otp_programming_mode_addr == $past(pwdata[12:0], 2) && otp_programming_mode_word == $past(word_q, 2)
      ##1 otp_programming_mode_en;
  endsequence
  chk_mode_drop: assert property (
    wr && paddr == OFS_MODE && pwdata[2:0] != otp_mode && otp_mode_ready |=> !otp_mode_ready)
    else $error("Mode change kept mode-ready high.");
  chk_mode_settle: assert property (
    $rose(otp_mode_ready) |-> low_n == SETTLE_CYC)
    else $error("Mode settle length wrong.");
  chk_mode_frozen: assert property (
    !otp_mode_ready |=> $stable(otp_mode))
    else $error("Mode moved during transition.");
  chk_load_launch: assert property (
    s_trig |-> s_launch)
    else $error("Request not launched as loaded.");
  chk_no_launch: assert property (
    wr && paddr == OFS_ADDR && otp_mode != MODE_PROGRAMMING_MODE && !otp_programming_mode_en |=> !otp_programming_mode_en [*3])
    else $error("Burn started outside programming mode.");
  chk_burn_len: assert property (
    $fell(otp_programming_mode_en) |-> burn_n == BURN_CYC)
    else $error("Burn length wrong.");
  chk_burn_mode: assert property (
    $rose(otp_programming_mode_en) |-> otp_mode == MODE_PROGRAMMING_MODE)
    else $error("Burn in wrong mode.");
  chk_req_steady: assert property (
    otp_programming_mode_en && $past(otp_programming_mode_en) |-> $stable(otp_programming_mode_addr) && $stable(otp_programming_mode_word))
    else $error("Request changed during burn.");
endmodule

bind opb_program_buffer opb_program_buffer_chk #(
  .SETTLE_CYC(SETTLE_CYC),
  .BURN_CYC(BURN_CYC)
) i_opb_program_buffer_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .otp_mode, .otp_mode_ready, .otp_programming_mode_en, .otp_programming_mode_addr, .otp_programming_mode_word
);

// >>> bench/opb_otp_model.sv
module opb_otp_model (
  input wire logic pclk,
  input wire logic otp_programming_mode_en,
  input wire logic [opb_pkg::PADDR_W-1:0] otp_programming_mode_addr,
  input wire logic [opb_pkg::WORD_W-1:0] otp_programming_mode_word,
  output int burns,
  output logic [opb_pkg::PADDR_W-1:0] cell_addr,
  output logic [opb_pkg::WORD_W-1:0] cell_word
);
  timeunit 1ns;
  timeprecision 1ns;
  import opb_pkg::*;
  logic en_q = 1'b0;
  initial burns = 0;
  // A held enable is one burn, so only its rising edge latches a cell.
  always @(posedge pclk)
  begin
    en_q <= otp_programming_mode_en;
    if (otp_programming_mode_en && !en_q)
    begin
      burns <= burns + 1;
      cell_addr <= otp_programming_mode_addr;
      cell_word <= otp_programming_mode_word;
    end
  end
endmodule

// >>> bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import opb_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic pready, pslverr, irq, otp_mode_ready, otp_programming_mode_en, er;
  logic [31:0] prdata, rd;
  logic [MODE_W-1:0] otp_mode;
  logic [PADDR_W-1:0] otp_programming_mode_addr, cell_addr;
  logic [WORD_W-1:0] otp_programming_mode_word, cell_word;
  int burns;
  int num_errors = 0;
  int check_count = 0;
  always #50 pclk = ~pclk;
  opb_program_buffer #(.SETTLE_CYC(4), .BURN_CYC(40)) i_opb_program_buffer (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .irq, .otp_mode, .otp_mode_ready, .otp_programming_mode_en, .otp_programming_mode_addr,
    .otp_programming_mode_word
  );
  opb_otp_model i_opb_otp_model (
    .pclk, .otp_programming_mode_en, .otp_programming_mode_addr, .otp_programming_mode_word, .burns, .cell_addr, .cell_word
  );
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  // The request stands until pready is seen high at a rising edge; read data is
  // taken at that edge. One idle cycle follows so psel is never driven twice in a step.
  task automatic rw(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      num_errors++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic settle(input logic [31:0] e);
    int n;
    n = 0;
    do
    begin
      rw(1'b0, OFS_STATUS, 32'h0);
      n++;
    end
    while (rd !== e && n < 50);
    cmp("status", e, rd);
    if (rd !== e)
      conclude();
  endtask
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rw(1'b0, OFS_STATUS, 32'h0);
    cmp("status", 32'h7, rd);
    rw(1'b0, OFS_ADDR, 32'h0);
    cmp("addr", 32'h0, rd);
    rw(1'b0, OFS_WORD, 32'h0);
    cmp("word", 32'h0, rd);
    rw(1'b0, 32'h07F40020, 32'h0);
    cmp("slverr", 32'h1, {31'h0, er});
    $display("test reset done");
    rw(1'b1, OFS_MODE, 32'h3);
    rw(1'b0, OFS_STATUS, 32'h0);
    cmp("status", 32'h3, rd);
    settle(32'h7);
    rw(1'b0, OFS_MODE, 32'h0);
    cmp("mode", 32'h3, rd);
    $display("test mode done");
    rw(1'b1, OFS_WORD, 32'hA5C30F1E);
    rw(1'b1, OFS_ADDR, 32'hFFFFE5A5);
    settle(32'h6);
    rw(1'b1, OFS_WORD, 32'h5A3CF0E1);
    rw(1'b0, OFS_STATUS, 32'h0);
    cmp("status", 32'h6, rd);
    rw(1'b1, OFS_ADDR, 32'h00001234);
    rw(1'b1, OFS_WORD, 32'h11111111);
    rw(1'b1, OFS_ADDR, 32'h00000000);
    rw(1'b0, OFS_WORD, 32'h0);
    cmp("word", 32'h5A3CF0E1, rd);
    rw(1'b0, OFS_ADDR, 32'h0);
    cmp("addr", 32'h00001234, rd);
    rw(1'b0, OFS_STATUS, 32'h0);
    cmp("status", 32'h4, rd);
    settle(32'h7);
    cmp("burns", 32'h2, 32'(burns));
    cmp("cell", 32'h1234, {19'h0, cell_addr});
    cmp("cell", 32'h5A3CF0E1, cell_word);
    $display("test program done");
    rw(1'b0, OFS_IRQ_ST, 32'h0);
    cmp("irqst", 32'h7, rd);
    cmp("irq", 32'h0, {31'h0, irq});
    rw(1'b1, OFS_IRQ_MASK, 32'h2);
    @(negedge pclk);
    cmp("irq", 32'h1, {31'h0, irq});
    rw(1'b1, OFS_IRQ_ST, 32'h2);
    @(negedge pclk);
    cmp("irq", 32'h0, {31'h0, irq});
    rw(1'b0, OFS_IRQ_ST, 32'h0);
    cmp("irqst", 32'h5, rd);
    $display("test irq done");
    rw(1'b1, OFS_MODE, 32'h2);
    settle(32'h7);
    rw(1'b1, OFS_WORD, 32'h12345678);
    rw(1'b1, OFS_ADDR, 32'h00000ABC);
    settle(32'h7);
    rw(1'b0, OFS_ADDR, 32'h0);
    cmp("addr", 32'h00000ABC, rd);
    cmp("burns", 32'h2, 32'(burns));
    $display("test other mode done");
    conclude();
  end
endmodule
